/* src/igp_params.svh */
// Purpose: named constants of the interrupt and port block
// Assumes: byte addresses on a 32-bit AHB-Lite slave
// Notes: definitions only
`ifndef IGP_PARAMS_SVH
`define IGP_PARAMS_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define IGP_OFS_GLOBAL_MODE_REG 8'h00
`define IGP_OFS_GLOBAL_IRQ_STATUS 8'h04
`define IGP_OFS_A_STAT 8'h08
`define IGP_OFS_A_MASK 8'h0C
`define IGP_OFS_B_STAT 8'h10
`define IGP_OFS_B_MASK 8'h14
`define IGP_OFS_D_STAT 8'h18
`define IGP_OFS_D_MASK 8'h1C
`define IGP_OFS_PS_LO 8'h20
`define IGP_OFS_PS_HI 8'h24
`define IGP_OFS_PM_LO 8'h28
`define IGP_OFS_PM_HI 8'h2C
`define IGP_OFS_DIR_LO 8'h30
`define IGP_OFS_DIR_HI 8'h34
`define IGP_OFS_DAT_LO 8'h38
`define IGP_OFS_DAT_HI 8'h3C
// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define IGP_GM_POL 0
`define IGP_GM_OD 1
`define IGP_GM_GIM 2
`define IGP_GM_DMA 3
`define IGP_GM_VIS_A 4
`define IGP_GM_VIS_B 5
`define IGP_GM_RNG 5:0
`define IGP_GLOBAL_MODE_REG_RST 6'h04
`define IGP_GS_A 0
`define IGP_GS_B 1
`define IGP_GS_D 2
`define IGP_GS_P 3
`define IGP_LO 7:0
`define IGP_HI 15:8
`define IGP_MASK_RST 8'hFF
`define IGP_PORT_ONES 16'hFFFF
`define IGP_PIN_ALWAYS 16'h0740
`define IGP_PIN_SHARED 16'h0007
`define IGP_HTRANS_ACT 1
`define IGP_HSIZE_WORD 3'h2
`define IGP_RESP_OKAY 1'b0
`endif

/* src/igp_pkg.sv */
// Purpose: shared types of the interrupt and port block
// Assumes: nothing
// Notes: constants live in igp_params.svh
package igp_pkg;
  typedef enum logic [1:0] {bus_idle, bus_wr, bus_rwait} igp_bus_t;
  typedef logic [15:0] igp_port_t;
  typedef logic [7:0] igp_byte_t;
endpackage : igp_pkg

/* src/igp_sync.sv */
// Purpose: two-flop synchroniser for the port pins
// Assumes: pins asynchronous to hclk
// Notes: first stage is read by the second stage only
`timescale 1ns/1ps
module igp_sync
  import igp_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire igp_port_t d_in,
  output igp_port_t q_out
);
  igp_port_t meta_reg;
  igp_port_t meta_next;
  igp_port_t sync_reg;
  igp_port_t sync_next;

  always_comb begin
    meta_next = d_in;
    sync_next = meta_reg;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign q_out = sync_reg;
endmodule : igp_sync

/* src/igp_sticky.sv */
// Purpose: sticky interrupt status bits with mask gating
// Assumes: set and clear come from hclk logic
// Notes: a set in the clearing cycle wins
`timescale 1ns/1ps
module igp_sticky
  import igp_pkg::*;
#(parameter int W = 8)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [W-1:0] set_in,
  input wire logic [W-1:0] clr_in,
  input wire logic [W-1:0] mask_in,
  input wire logic vis_in,
  output logic [W-1:0] status,
  output logic pend
);
  logic [W-1:0] status_reg;
  logic [W-1:0] status_next;
  genvar i;

  generate
    for (i = 0; i < W; i++) begin : g_bit
      assign status_next[i] = (set_in[i] && (vis_in || !mask_in[i])) ||
                              (status_reg[i] && !clr_in[i]);
    end
  endgenerate

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_reg <= '0;
    end else begin
      status_reg <= status_next;
    end
  end

  assign status = status_reg;
  assign pend = |(status_reg & ~mask_in);

  set_wins_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (set_in[0] && !mask_in[0]) |=> status_reg[0])
    else $error("set lost against clear");
  hidden_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (set_in[0] && mask_in[0] && !vis_in && !status_reg[0])
    |=> !status_reg[0])
    else $error("masked event became visible");
endmodule : igp_sticky

/* src/igp_top.sv */
// Purpose: interrupt aggregation and general port pins, AHB-Lite slave
// Assumes: one AHB slave, hclk 100 MHz, word accesses
// Notes: status reads clear; writing ones also clears
//
// Function
// - one irq output, drive and level configurable
// - global status points to pending sources
// - mask bit zero lets status interrupt
// - visible mode shows masked channel events
// - reading status returns and clears bits
// - global mask resets set, blocks all
// - four pins always, three without dma
// - direction bit zero output, reset input
// - output pins drive port data bits
// - data read returns available pin levels, others zero
// - input pins sampled every rising edge
// - input transition sets port status bit
// - port summary set while port pending
//
// Implementation choices: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`include "igp_params.svh"
module igp_top
  import igp_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire igp_byte_t chan_a_event,
  input wire igp_byte_t chan_b_event,
  input wire igp_byte_t dma_event,
  input wire igp_port_t gp_in,
  output igp_port_t gp_out,
  output igp_port_t gp_oe,
  output logic irq_out,
  output logic irq_oe
);
  // ----------------------------------------
  // declarations
  // ----------------------------------------
  igp_bus_t bus_reg;
  igp_bus_t bus_next;
  logic [7:0] addr_reg;
  logic [7:0] addr_next;
  logic rdy_reg;
  logic rdy_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [5:0] global_mode_reg_reg;
  logic [5:0] global_mode_reg_next;
  igp_byte_t amask_reg;
  igp_byte_t amask_next;
  igp_byte_t bmask_reg;
  igp_byte_t bmask_next;
  igp_byte_t dmask_reg;
  igp_byte_t dmask_next;
  igp_port_t pmask_reg;
  igp_port_t pmask_next;
  igp_port_t dir_reg;
  igp_port_t dir_next;
  igp_port_t dat_reg;
  igp_port_t dat_next;
  igp_port_t prev_reg;
  igp_port_t prev_next;
  igp_port_t oe_reg;
  igp_port_t oe_next;
  igp_port_t out_reg;
  igp_port_t out_next;
  logic irq_reg;
  logic irq_next;
  logic irqoe_reg;
  logic irqoe_next;
  logic act_reg;
  logic act_next;
  igp_port_t pin_lvl;
  igp_port_t avail;
  igp_port_t port_set;
  igp_port_t port_clr;
  igp_port_t port_stat;
  igp_byte_t a_stat;
  igp_byte_t b_stat;
  igp_byte_t d_stat;
  igp_byte_t a_clr;
  igp_byte_t b_clr;
  igp_byte_t d_clr;
  igp_byte_t wd;
  igp_byte_t rd_mux;
  igp_byte_t global_irq_status;
  logic a_pend;
  logic b_pend;
  logic d_pend;
  logic p_pend;
  logic any_pend;
  logic accept;
  logic wr_en;
  logic rd_en;

  // ----------------------------------------
  // pin sampling and transitions
  // ----------------------------------------
  // sample pins each edge
  igp_sync u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .d_in(gp_in),
    .q_out(pin_lvl)
  );

  assign avail = `IGP_PIN_ALWAYS |
    (global_mode_reg_reg[`IGP_GM_DMA] ? '0 : `IGP_PIN_SHARED);
  assign port_set = (pin_lvl ^ prev_reg) & avail & dir_reg;

  // ----------------------------------------
  // sticky status banks
  // ----------------------------------------
  assign wd = hwdata[`IGP_LO];
  assign wr_en = (bus_reg == bus_wr);
  assign rd_en = (bus_reg == bus_rwait);

  always_comb begin
    a_clr = '0;
    b_clr = '0;
    d_clr = '0;
    port_clr = '0;
    if (rd_en) begin
      case (addr_reg)
        `IGP_OFS_A_STAT: a_clr = '1;
        `IGP_OFS_B_STAT: b_clr = '1;
        `IGP_OFS_D_STAT: d_clr = '1;
        `IGP_OFS_PS_LO: port_clr[`IGP_LO] = '1;
        `IGP_OFS_PS_HI: port_clr[`IGP_HI] = '1;
        default: a_clr = '0;
      endcase
    end else if (wr_en) begin
      case (addr_reg)
        `IGP_OFS_A_STAT: a_clr = wd;
        `IGP_OFS_B_STAT: b_clr = wd;
        `IGP_OFS_D_STAT: d_clr = wd;
        `IGP_OFS_PS_LO: port_clr[`IGP_LO] = wd;
        `IGP_OFS_PS_HI: port_clr[`IGP_HI] = wd;
        default: a_clr = '0;
      endcase
    end
  end

  igp_sticky #(.W(8)) u_chan_a (
    .hclk(hclk), .hresetn(hresetn), .set_in(chan_a_event),
    .clr_in(a_clr), .mask_in(amask_reg),
    .vis_in(global_mode_reg_reg[`IGP_GM_VIS_A]), .status(a_stat), .pend(a_pend)
  );
  igp_sticky #(.W(8)) u_chan_b (
    .hclk(hclk), .hresetn(hresetn), .set_in(chan_b_event),
    .clr_in(b_clr), .mask_in(bmask_reg),
    .vis_in(global_mode_reg_reg[`IGP_GM_VIS_B]), .status(b_stat), .pend(b_pend)
  );
  igp_sticky #(.W(8)) u_dma (
    .hclk(hclk), .hresetn(hresetn), .set_in(dma_event),
    .clr_in(d_clr), .mask_in(dmask_reg),
    .vis_in(1'b1), .status(d_stat), .pend(d_pend)
  );
  igp_sticky #(.W(16)) u_port (
    .hclk(hclk), .hresetn(hresetn), .set_in(port_set),
    .clr_in(port_clr), .mask_in(pmask_reg),
    .vis_in(1'b1), .status(port_stat), .pend(p_pend)
  );

  always_comb begin
    global_irq_status = '0;
    global_irq_status[`IGP_GS_A] = a_pend;
    global_irq_status[`IGP_GS_B] = b_pend;
    global_irq_status[`IGP_GS_D] = d_pend;
    global_irq_status[`IGP_GS_P] = p_pend;
  end

  // ----------------------------------------
  // bus slave
  // ----------------------------------------
  assign accept = hsel && hready && htrans[`IGP_HTRANS_ACT];

  always_comb begin
    case (addr_reg)
      `IGP_OFS_GLOBAL_MODE_REG: rd_mux = {2'h0, global_mode_reg_reg};
      `IGP_OFS_GLOBAL_IRQ_STATUS: rd_mux = global_irq_status;
      `IGP_OFS_A_STAT: rd_mux = a_stat;
      `IGP_OFS_A_MASK: rd_mux = amask_reg;
      `IGP_OFS_B_STAT: rd_mux = b_stat;
      `IGP_OFS_B_MASK: rd_mux = bmask_reg;
      `IGP_OFS_D_STAT: rd_mux = d_stat;
      `IGP_OFS_D_MASK: rd_mux = dmask_reg;
      `IGP_OFS_PS_LO: rd_mux = port_stat[`IGP_LO];
      `IGP_OFS_PS_HI: rd_mux = port_stat[`IGP_HI];
      `IGP_OFS_PM_LO: rd_mux = pmask_reg[`IGP_LO];
      `IGP_OFS_PM_HI: rd_mux = pmask_reg[`IGP_HI];
      `IGP_OFS_DIR_LO: rd_mux = dir_reg[`IGP_LO];
      `IGP_OFS_DIR_HI: rd_mux = dir_reg[`IGP_HI];
      `IGP_OFS_DAT_LO: rd_mux = pin_lvl[`IGP_LO] & avail[`IGP_LO];
      `IGP_OFS_DAT_HI: rd_mux = pin_lvl[`IGP_HI] & avail[`IGP_HI];
      default: rd_mux = '0;
    endcase
  end

  // one wait state on reads keeps hrdata registered
  always_comb begin
    bus_next = bus_reg;
    addr_next = addr_reg;
    rdy_next = rdy_reg;
    rdata_next = rdata_reg;
    case (bus_reg)
      bus_rwait: begin
        rdata_next = {24'h000000, rd_mux};
        bus_next = bus_idle;
        rdy_next = 1'b1;
      end
      default: begin
        bus_next = bus_idle;
        rdy_next = 1'b1;
        if (accept) begin
          addr_next = haddr[7:0];
          if (!hwrite) begin
            bus_next = bus_rwait;
            rdy_next = 1'b0;
          end else if (hsize == `IGP_HSIZE_WORD) begin
            bus_next = bus_wr;
          end
        end
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_reg <= bus_idle;
      addr_reg <= '0;
      rdy_reg <= 1'b1;
      rdata_reg <= '0;
    end else begin
      bus_reg <= bus_next;
      addr_reg <= addr_next;
      rdy_reg <= rdy_next;
      rdata_reg <= rdata_next;
    end
  end

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  always_comb begin
    global_mode_reg_next = global_mode_reg_reg;
    amask_next = amask_reg;
    bmask_next = bmask_reg;
    dmask_next = dmask_reg;
    pmask_next = pmask_reg;
    dir_next = dir_reg;
    dat_next = dat_reg;
    if (wr_en) begin
      case (addr_reg)
        `IGP_OFS_GLOBAL_MODE_REG: global_mode_reg_next = hwdata[`IGP_GM_RNG];
        `IGP_OFS_A_MASK: amask_next = wd;
        `IGP_OFS_B_MASK: bmask_next = wd;
        `IGP_OFS_D_MASK: dmask_next = wd;
        `IGP_OFS_PM_LO: pmask_next[`IGP_LO] = wd;
        `IGP_OFS_PM_HI: pmask_next[`IGP_HI] = wd;
        `IGP_OFS_DIR_LO: dir_next[`IGP_LO] = wd;
        `IGP_OFS_DIR_HI: dir_next[`IGP_HI] = wd;
        `IGP_OFS_DAT_LO: dat_next[`IGP_LO] = wd;
        `IGP_OFS_DAT_HI: dat_next[`IGP_HI] = wd;
        default: global_mode_reg_next = global_mode_reg_reg;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      global_mode_reg_reg <= `IGP_GLOBAL_MODE_REG_RST;
      amask_reg <= `IGP_MASK_RST;
      bmask_reg <= `IGP_MASK_RST;
      dmask_reg <= `IGP_MASK_RST;
      pmask_reg <= `IGP_PORT_ONES;
      dir_reg <= `IGP_PORT_ONES;
      dat_reg <= '0;
    end else begin
      global_mode_reg_reg <= global_mode_reg_next;
      amask_reg <= amask_next;
      bmask_reg <= bmask_next;
      dmask_reg <= dmask_next;
      pmask_reg <= pmask_next;
      dir_reg <= dir_next;
      dat_reg <= dat_next;
    end
  end

  // ----------------------------------------
  // pin drivers and interrupt output
  // ----------------------------------------
  // global mask blocks all
  assign any_pend = (a_pend || b_pend || d_pend || p_pend) &&
                    !global_mode_reg_reg[`IGP_GM_GIM];

  always_comb begin
    prev_next = pin_lvl;
    oe_next = avail & ~dir_reg;
    out_next = dat_reg & oe_next;
    act_next = any_pend;
    if (global_mode_reg_reg[`IGP_GM_OD]) begin
      irqoe_next = any_pend;
      irq_next = global_mode_reg_reg[`IGP_GM_POL];
    end else begin
      irqoe_next = 1'b1;
      irq_next = ~(any_pend ^ global_mode_reg_reg[`IGP_GM_POL]);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_reg <= '0;
      oe_reg <= '0;
      out_reg <= '0;
      act_reg <= 1'b0;
      irqoe_reg <= 1'b1;
      irq_reg <= 1'b1;
    end else begin
      prev_reg <= prev_next;
      oe_reg <= oe_next;
      out_reg <= out_next;
      act_reg <= act_next;
      irqoe_reg <= irqoe_next;
      irq_reg <= irq_next;
    end
  end

  assign hreadyout = rdy_reg;
  assign hrdata = rdata_reg;
  assign hresp = `IGP_RESP_OKAY;
  assign gp_out = out_reg;
  assign gp_oe = oe_reg;
  assign irq_out = irq_reg;
  assign irq_oe = irqoe_reg;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  irq_pushpull_a: assert property (
    !global_mode_reg_reg[`IGP_GM_OD] |=>
      irqoe_reg && (irq_reg == (act_reg == $past(global_mode_reg_reg[`IGP_GM_POL]))))
    else $error("push-pull irq level wrong");
  irq_opendrain_a: assert property (
    global_mode_reg_reg[`IGP_GM_OD] |=> (irqoe_reg == act_reg))
    else $error("open-drain enable wrong");
  gim_block_a: assert property (
    global_mode_reg_reg[`IGP_GM_GIM] |=> !act_reg)
    else $error("irq active under global mask");
  mask_gate_a: assert property (
    (a_pend || b_pend || d_pend || p_pend) == 1'b0 |=> !act_reg)
    else $error("irq with nothing unmasked");
  rd_clear_a: assert property (
    (rd_en && addr_reg == `IGP_OFS_A_STAT && chan_a_event == '0)
    |=> (a_stat == '0) && (hrdata[`IGP_LO] == $past(a_stat)))
    else $error("status read did not clear");
  shared_pin_a: assert property (
    global_mode_reg_reg[`IGP_GM_DMA] |=> (gp_oe & `IGP_PIN_SHARED) == '0)
    else $error("shared pin driven with dma");
  dir_drive_a: assert property (
    1'b1 |=> gp_oe == ($past(avail) & ~$past(dir_reg)) &&
      gp_out == ($past(dat_reg) & $past(avail) & ~$past(dir_reg)))
    else $error("pin drive mismatch");
  port_event_a: assert property (
    port_set != '0 |=> (port_stat & $past(port_set)) == $past(port_set))
    else $error("transition not recorded");
  port_sum_a: assert property (
    ((port_set & ~pmask_reg) != '0) && !wr_en |=> global_irq_status[`IGP_GS_P])
    else $error("port summary wrong");
  read_wait_a: assert property (
    (accept && !hwrite && rdy_reg) |=> !hreadyout ##1 hreadyout)
    else $error("read answer timing wrong");

  irq_seen_c: cover property (act_reg ##1 !act_reg);
  port_irq_c: cover property (p_pend && !global_mode_reg_reg[`IGP_GM_GIM]);
  vis_c: cover property (a_stat != '0 && !a_pend);
  set_clear_c: cover property (rd_en && port_set != '0);
endmodule : igp_top

/* dv/igp_host.sv */
// Purpose: cpu model, single AHB-Lite master for register access
// Assumes: one slave, hready tied to its hreadyout
// Notes: waits have no limit of their own; the bench watchdog ends a hang
`timescale 1ns/1ps
module igp_host
  import igp_pkg::*;
(
  input wire logic hclk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  // ----------------------------------------
  // one word transfer
  // ----------------------------------------
  // cause found by reads
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    do begin
      @(posedge hclk);
    end while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do begin
      @(posedge hclk);
    end while (hready !== 1'b1);
    q = hrdata;
  endtask : xfer
endmodule : igp_host

/* dv/igp_top_tb.sv */
// Purpose: self-checking bench of the interrupt and port block
// Assumes: pins settle through a two-flop sync
// Notes: a driven pin reads back its own output level
`timescale 1ns/1ps
`include "igp_params.svh"
module igp_top_tb
  import igp_pkg::*;
;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq_out, irq_oe;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  igp_byte_t ev_a, ev_b, ev_d;
  igp_port_t pin_ext, gp_in, gp_out, gp_oe;
  int err_total = 0;
  int n_compared = 0;
  // undriven pins follow the outside level
  assign gp_in = (gp_oe & gp_out) | (~gp_oe & pin_ext);
  igp_top u_igp_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .chan_a_event(ev_a),
    .chan_b_event(ev_b), .dma_event(ev_d), .gp_in(gp_in),
    .gp_out(gp_out), .gp_oe(gp_oe), .irq_out(irq_out), .irq_oe(irq_oe));
  igp_host u_igp_host (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : chk
  task automatic settle(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask : settle
  // register effects land one edge after the data phase
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    u_igp_host.xfer(1'b1, a, d, q);
    settle(2);
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    u_igp_host.xfer(1'b0, a, 32'h0, q);
    chk(q, exp);
    chk(32'(hresp), 32'h0);
    settle(2);
  endtask : rd_chk
  task automatic pulse(input igp_byte_t a, input igp_byte_t b,
                       input igp_byte_t d);
    @(posedge hclk);
    ev_a <= a;
    ev_b <= b;
    ev_d <= d;
    @(posedge hclk);
    ev_a <= 8'h00;
    ev_b <= 8'h00;
    ev_d <= 8'h00;
    settle(3);
  endtask : pulse
  task automatic set_pins(input igp_port_t v);
    @(posedge hclk);
    pin_ext <= v;
    settle(5);
  endtask : set_pins
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    chk(32'({irq_oe, irq_out}), 32'h3);
    chk(32'(gp_oe), 32'h0);
    rd_chk(`IGP_OFS_GLOBAL_MODE_REG, 32'h04);
    rd_chk(`IGP_OFS_A_MASK, 32'hFF);
    rd_chk(`IGP_OFS_PM_HI, 32'hFF);
    rd_chk(`IGP_OFS_DIR_LO, 32'hFF);
    rd_chk(`IGP_OFS_DIR_HI, 32'hFF);
    rd_chk(8'h80, 32'h0);
  endtask : t_reset
  task automatic t_chan();
    wr(`IGP_OFS_A_MASK, 32'hFE);
    wr(`IGP_OFS_GLOBAL_MODE_REG, 32'h00);
    pulse(8'h01, 8'h04, 8'h02);
    chk(32'(irq_out), 32'h0);
    rd_chk(`IGP_OFS_GLOBAL_IRQ_STATUS, 32'h01);
    rd_chk(`IGP_OFS_B_STAT, 32'h00);
    rd_chk(`IGP_OFS_D_STAT, 32'h02);
    rd_chk(`IGP_OFS_A_STAT, 32'h01);
    rd_chk(`IGP_OFS_A_STAT, 32'h00);
    chk(32'(irq_out), 32'h1);
  endtask : t_chan
  task automatic t_vis_gim();
    wr(`IGP_OFS_GLOBAL_MODE_REG, 32'h10);
    pulse(8'h80, 8'h00, 8'h00);
    chk(32'(irq_out), 32'h1);
    rd_chk(`IGP_OFS_GLOBAL_IRQ_STATUS, 32'h00);
    rd_chk(`IGP_OFS_A_STAT, 32'h80);
    wr(`IGP_OFS_GLOBAL_MODE_REG, 32'h20);
    wr(`IGP_OFS_D_MASK, 32'hFD);
    pulse(8'h00, 8'h08, 8'h02);
    chk(32'(irq_out), 32'h0);
    rd_chk(`IGP_OFS_GLOBAL_IRQ_STATUS, 32'h04);
    rd_chk(`IGP_OFS_B_STAT, 32'h08);
    wr(`IGP_OFS_D_STAT, 32'h02);
    rd_chk(`IGP_OFS_D_STAT, 32'h00);
    chk(32'(irq_out), 32'h1);
    wr(`IGP_OFS_GLOBAL_MODE_REG, 32'h04);
    pulse(8'h01, 8'h00, 8'h00);
    chk(32'(irq_out), 32'h1);
    wr(`IGP_OFS_GLOBAL_MODE_REG, 32'h00);
    chk(32'(irq_out), 32'h0);
    rd_chk(`IGP_OFS_A_STAT, 32'h01);
  endtask : t_vis_gim
  task automatic t_drive();
    logic [1:0] m;
    for (int i = 0; i < 4; i++) begin
      m = i[1:0];
      pulse(8'h01, 8'h00, 8'h00);
      wr(`IGP_OFS_GLOBAL_MODE_REG, 32'(m));
      chk(32'({irq_oe, irq_out}), 32'({1'b1, m[0]}));
      rd_chk(`IGP_OFS_A_STAT, 32'h01);
      chk(32'({irq_oe, irq_out}), 32'({~m[1], m[1] ? m[0] : ~m[0]}));
    end
    wr(`IGP_OFS_GLOBAL_MODE_REG, 32'h00);
  endtask : t_drive
  task automatic t_port();
    wr(`IGP_OFS_DIR_LO, 32'hBF);
    wr(`IGP_OFS_DAT_LO, 32'h40);
    chk(32'({gp_oe, gp_out}), {16'h0040, 16'h0040});
    rd_chk(`IGP_OFS_DAT_LO, 32'h40);
    wr(`IGP_OFS_PM_HI, 32'hFE);
    set_pins(16'h0100);
    chk(32'(irq_out), 32'h0);
    rd_chk(`IGP_OFS_GLOBAL_IRQ_STATUS, 32'h08);
    rd_chk(`IGP_OFS_DAT_HI, 32'h01);
    rd_chk(`IGP_OFS_PS_HI, 32'h01);
    chk(32'(irq_out), 32'h1);
    set_pins(16'h0200);
    rd_chk(`IGP_OFS_PS_HI, 32'h03);
    rd_chk(`IGP_OFS_GLOBAL_IRQ_STATUS, 32'h00);
    wr(`IGP_OFS_DAT_LO, 32'h00);
    chk(32'(gp_out), 32'h0);
    wr(`IGP_OFS_GLOBAL_MODE_REG, 32'h08);
    set_pins(16'h0009);
    rd_chk(`IGP_OFS_DAT_LO, 32'h00);
    rd_chk(`IGP_OFS_PS_LO, 32'h00);
    wr(`IGP_OFS_GLOBAL_MODE_REG, 32'h00);
    settle(4);
    rd_chk(`IGP_OFS_DAT_LO, 32'h01);
  endtask : t_port
  // ----------------------------------------
  // run control
  // ----------------------------------------
  task automatic print_verdict();
    if (err_total == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  // whole run is a few hundred cycles
  initial begin
    #500us;
    err_total++;
    print_verdict();
  end
  initial begin
    hresetn = 1'b0;
    ev_a = 8'h00;
    ev_b = 8'h00;
    ev_d = 8'h00;
    pin_ext = 16'h0000;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    settle(1);
    t_reset();
    t_chan();
    t_vis_gim();
    t_drive();
    t_port();
    print_verdict();
  end
endmodule : igp_top_tb
